//--- verilog/tuner_ctl_pkg.sv
// Constants shared by the tuning message handler and its confirm sender.
package tuner_ctl_pkg;

	// --------------------------------------------------------------------
	// Message tags.
	// --------------------------------------------------------------------
	localparam logic [23:0] TAG_TX_REQ = 24'h9f8404;
	localparam logic [23:0] TAG_TX_CNF = 24'h9f8405;
	localparam logic [23:0] TAG_RX_REQ = 24'h9f8406;
	localparam logic [23:0] TAG_RX_CNF = 24'h9f8407;
	localparam logic [23:0] TAG_IB_REQ = 24'h9f8408;
	localparam logic [23:0] TAG_IB_CNF = 24'h9f8409;

	// --------------------------------------------------------------------
	// Message layout: three tag bytes, one length byte, then payload.
	// --------------------------------------------------------------------
	localparam logic [3:0] POS_LEN     = 4'h3;
	localparam logic [3:0] POS_PAYLOAD = 4'h4;
	localparam logic [3:0] POS_MAX     = 4'h8;
	localparam logic [3:0] TX_PAY_LEN  = 4'h4;
	localparam logic [3:0] RX_PAY_LEN  = 4'h3;
	localparam logic [3:0] IB_ORG_LEN  = 4'h3;
	localparam logic [3:0] IB_FRQ_LEN  = 4'h4;
	localparam logic [7:0] CNF_LEN_1   = 8'h01;
	localparam logic [7:0] CNF_LEN_2   = 8'h02;
	localparam logic [2:0] IDX_LEN     = 3'h3;
	localparam logic [2:0] IDX_LTS     = 3'h4;
	localparam logic [2:0] IDX_LAST_1  = 3'h4;
	localparam logic [2:0] IDX_LAST_2  = 3'h5;

	// --------------------------------------------------------------------
	// Status codes.
	// --------------------------------------------------------------------
	localparam logic [7:0] ST_GRANTED  = 8'h00;
	localparam logic [7:0] ST_NO_PHYS  = 8'h01;
	localparam logic [7:0] ST_BUSY     = 8'h02;
	localparam logic [7:0] ST_BAD_PARM = 8'h03;
	localparam logic [7:0] ST_OTHER    = 8'h04;
	localparam logic [7:0] ST_RESERVED = 8'h05;
	localparam logic [7:0] IB_ACCEPTED = 8'h00;
	localparam logic [7:0] IB_BAD_FREQ = 8'h01;
	localparam logic [7:0] IB_BAD_MOD  = 8'h02;
	localparam logic [7:0] IB_HW_FAIL  = 8'h03;
	localparam logic [7:0] IB_BUSY     = 8'h04;

	// --------------------------------------------------------------------
	// Field codes and decoded values.
	// --------------------------------------------------------------------
	localparam logic [1:0]  RATE_00      = 2'h0;
	localparam logic [1:0]  RATE_01      = 2'h1;
	localparam logic [1:0]  RATE_10      = 2'h2;
	localparam logic [11:0] KBPS_256     = 12'h100;
	localparam logic [11:0] KBPS_1544    = 12'h608;
	localparam logic [11:0] KBPS_2048    = 12'h800;
	localparam logic [11:0] KBPS_3088    = 12'hc10;
	localparam int          RATE_MSB     = 7;
	localparam int          RATE_LSB     = 6;
	localparam int          FLIP_BIT     = 0;
	localparam int          RX_HI_ZERO_M = 7;
	localparam int          RX_HI_ZERO_L = 3;
	localparam logic [7:0]  TYPE_ORIGIN  = 8'h00;
	localparam logic [7:0]  TYPE_FREQ    = 8'h01;
	localparam logic [7:0]  MOD_64QAM    = 8'h00;
	localparam logic [7:0]  MOD_256QAM   = 8'h01;
	localparam logic [21:0] STEP_KHZ     = 22'h000032;
	localparam logic [17:0] RX_BASE_KHZ  = 18'h0c350;

	// --------------------------------------------------------------------
	// Timing.
	// --------------------------------------------------------------------
	localparam int CLK_PERIOD_NS      = 10;
	localparam int RX_DEADLINE_MS     = 500;
	localparam int RX_DEADLINE_CYCLES = RX_DEADLINE_MS * 1000000 / CLK_PERIOD_NS;

endpackage

//--- verilog/confirm_sender.sv
// Serialises one confirm message onto the outgoing byte stream.
module confirm_sender (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [23:0] tag,
	input  wire logic [7:0]  status,
	input  wire logic        lts_en,
	input  wire logic [7:0]  lts,
	input  wire logic        out_ready,
	output logic             out_valid,
	output logic [7:0]       out_byte,
	output logic             out_last,
	output logic             busy
);

	typedef struct packed {
		logic        busy;
		logic [2:0]  idx;
		logic        valid;
		logic [7:0]  data;
		logic        last;
		logic [23:0] tag;
		logic [7:0]  status;
		logic        lts_en;
		logic [7:0]  lts;
	} snd_t;

	snd_t s_q;
	snd_t s_d;

	// Byte at position i of a confirm; the stream identifier only when enabled.
	function automatic logic [7:0] pick(input logic [23:0] t, input logic [7:0] st,
			input logic en, input logic [7:0] l, input logic [2:0] i);
		logic [7:0] b;
		b = st;
		if (i == 3'h0) begin
			b = t[23:16];
		end else if (i == 3'h1) begin
			b = t[15:8];
		end else if (i == 3'h2) begin
			b = t[7:0];
		end else if (i == tuner_ctl_pkg::IDX_LEN) begin
			b = en ? tuner_ctl_pkg::CNF_LEN_2 : tuner_ctl_pkg::CNF_LEN_1;
		end else if (i == tuner_ctl_pkg::IDX_LTS && en) begin
			b = l;
		end
		return b;
	endfunction

	// Load on start, advance one byte per accepted beat.
	always_comb begin
		s_d = s_q;
		if (start && !s_q.busy) begin
			s_d.busy   = 1'b1;
			s_d.idx    = 3'h0;
			s_d.valid  = 1'b1;
			s_d.tag    = tag;
			s_d.status = status;
			s_d.lts_en = lts_en;
			s_d.lts    = lts;
			s_d.data   = pick(tag, status, lts_en, lts, 3'h0);
			s_d.last   = 1'b0;
		end else if (s_q.valid && out_ready) begin
			if (s_q.last) begin
				s_d.valid = 1'b0;
				s_d.busy  = 1'b0;
			end else begin
				s_d.idx  = s_q.idx + 3'h1;
				s_d.data = pick(s_q.tag, s_q.status, s_q.lts_en, s_q.lts, s_d.idx);
				s_d.last = s_d.idx == (s_q.lts_en ? tuner_ctl_pkg::IDX_LAST_2 : tuner_ctl_pkg::IDX_LAST_1);
			end
		end
	end

	// State register.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign out_valid = s_q.valid;
	assign out_byte  = s_q.data;
	assign out_last  = s_q.last;
	assign busy      = s_q.busy;

endmodule

//--- verilog/tuner_control_message_handler.sv
// Decodes card tuning requests, drives the tuners and returns confirms.
// Notes on behaviour
// - Transmitter request is answered by a transmitter confirm with one status byte.
// - Granted and configured transmitter returns status zero.
// - No return path always returns transmitter not physically available.
// - Transmitter parameter out of host range returns invalid parameters.
// - Busy or other-reason codes otherwise; codes five and up never sent.
// - Receiver frequency is value times 50 kHz plus 50 MHz; top five bits zero.
// - Receiver rate bits 7:6: 00/01 2048, 10 1544, 11 3088 kbps.
// - Receiver rate bit 0 set means inverted spectrum.
// - Receiver confirm only after acquisition or 500 ms, whichever first; the code sends status one to three confirms at once, without waiting.
// - Receiver confirm carries tag and one status byte, codes zero to four.
// - Inband request: tune type, then origin number or frequency plus modulation.
// - Origin number zero means channel without programming source.
// - Inband frequency is field value times 50 kHz.
// - Modulation zero is 64QAM, one is 256QAM, others reserved.
// - Every inband request is answered by an inband confirm.
// - Inband status: accepted, bad frequency, bad modulation, hardware failure, busy.
// - Multi-stream mode inserts a stream identifier ahead of the inband status.
// - Transmitter rate bits 7:6: 00 256, 10 1544, 11 3088; 01 reserved.
module tuner_control_message_handler #(
	parameter int unsigned RX_DEADLINE_CYCLES = tuner_ctl_pkg::RX_DEADLINE_CYCLES,
	parameter logic [15:0] TX_FREQ_MIN_KHZ    = 16'h1388,
	parameter logic [15:0] TX_FREQ_MAX_KHZ    = 16'hc350,
	parameter logic [21:0] IB_FREQ_MIN_KHZ    = 22'h00c350,
	parameter logic [21:0] IB_FREQ_MAX_KHZ    = 22'h0f4240
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        in_valid,
	input  wire logic [7:0]  in_byte,
	input  wire logic        in_last,
	output logic             in_ready,
	output logic             out_valid,
	output logic [7:0]       out_byte,
	output logic             out_last,
	input  wire logic        out_ready,
	input  wire logic        return_path_present,
	input  wire logic        tx_busy,
	input  wire logic        rx_present,
	input  wire logic        rx_busy,
	input  wire logic        rx_acquired,
	input  wire logic        ib_busy,
	input  wire logic        ib_hw_fail,
	input  wire logic        multi_stream_mode,
	input  wire logic [7:0]  local_stream_id,
	output logic             tx_apply,
	output logic [15:0]      tx_freq_khz,
	output logic [7:0]       tx_power,
	output logic [11:0]      tx_rate_kbps,
	output logic             rx_apply,
	output logic [17:0]      receiver_carrier_setting,
	output logic [11:0]      rx_rate_kbps,
	output logic             spectrum_flip_flag,
	output logic             ib_apply,
	output logic             ib_by_origin,
	output logic [15:0]      programming_origin_number,
	output logic             ib_no_origin,
	output logic [21:0]      ib_freq_khz,
	output logic             ib_qam256
);

	// --------------------------------------------------------------------
	// State.
	// --------------------------------------------------------------------
	typedef enum logic [1:0] {
		COLLECT = 2'h0,
		EVAL    = 2'h1,
		RX_WAIT = 2'h3
	} state_t;

	typedef struct packed {
		state_t           st;
		logic [3:0]       pos;
		logic [23:0]      tag;
		logic [3:0][7:0]  pay;
		logic             in_ready;
		logic             start;
		logic [23:0]      cnf_tag;
		logic [7:0]       status;
		logic             lts_en;
		logic [7:0]       lts;
		logic [25:0]      timer;
		logic             tx_apply;
		logic [15:0]      tx_freq;
		logic [7:0]       tx_power;
		logic [11:0]      tx_rate;
		logic             rx_apply;
		logic [17:0]      rx_freq;
		logic [11:0]      rx_rate;
		logic             rx_flip;
		logic             ib_apply;
		logic             ib_by_origin;
		logic [15:0]      origin;
		logic             ib_no_origin;
		logic [21:0]      ib_freq;
		logic             ib_qam256;
	} hnd_t;

	hnd_t s_q;
	hnd_t s_d;
	logic ser_busy;
	logic [3:0] plen;
	logic [21:0] tx_f;
	logic [21:0] ib_f;
	// Bit positions of the rate field and of the receiver frequency bits that must be zero.
	localparam int RATE_MSB_I = tuner_ctl_pkg::RATE_MSB;
	localparam int RATE_LSB_I = tuner_ctl_pkg::RATE_LSB;
	localparam int RX_HI_M    = tuner_ctl_pkg::RX_HI_ZERO_M;
	localparam int RX_HI_L    = tuner_ctl_pkg::RX_HI_ZERO_L;

	// Scales a 16-bit field in 50 kHz steps to kHz.
	function automatic logic [21:0] freq_x50(input logic [15:0] v);
		return 22'(v) * tuner_ctl_pkg::STEP_KHZ;
	endfunction

	assign plen = (s_q.pos > tuner_ctl_pkg::POS_PAYLOAD) ? s_q.pos - tuner_ctl_pkg::POS_PAYLOAD : 4'h0;
	assign tx_f = 22'({s_q.pay[0], s_q.pay[1]});
	assign ib_f = freq_x50({s_q.pay[1], s_q.pay[2]});

	// --------------------------------------------------------------------
	// Request decode and confirm selection.
	// --------------------------------------------------------------------
	always_comb begin
		s_d          = s_q;
		s_d.start    = 1'b0;
		s_d.tx_apply = 1'b0;
		s_d.rx_apply = 1'b0;
		s_d.ib_apply = 1'b0;
		unique case (s_q.st)
			COLLECT: begin
				// Tag bytes shift in, the length byte is skipped, payload is kept.
				if (in_valid && s_q.in_ready) begin
					if (s_q.pos < tuner_ctl_pkg::POS_LEN) begin
						s_d.tag = {s_q.tag[15:0], in_byte};
					end else if (s_q.pos >= tuner_ctl_pkg::POS_PAYLOAD && s_q.pos < tuner_ctl_pkg::POS_MAX) begin
						s_d.pay[2'(s_q.pos - tuner_ctl_pkg::POS_PAYLOAD)] = in_byte;
					end
					if (s_q.pos < tuner_ctl_pkg::POS_MAX) begin
						s_d.pos = s_q.pos + 4'h1;
					end
					if (in_last) begin
						s_d.st = EVAL;
					end
				end
			end
			EVAL: begin
				s_d.st      = COLLECT;
				s_d.pos     = 4'h0;
				s_d.lts_en  = 1'b0;
				s_d.lts     = local_stream_id;
				if (s_q.tag == tuner_ctl_pkg::TAG_TX_REQ) begin
					s_d.start   = 1'b1;
					s_d.cnf_tag = tuner_ctl_pkg::TAG_TX_CNF;
					if (!return_path_present) begin
						s_d.status = tuner_ctl_pkg::ST_NO_PHYS;
					end else if (plen < tuner_ctl_pkg::TX_PAY_LEN
							|| s_q.pay[3][RATE_MSB_I:RATE_LSB_I] == tuner_ctl_pkg::RATE_01
							|| tx_f[15:0] < TX_FREQ_MIN_KHZ || tx_f[15:0] > TX_FREQ_MAX_KHZ) begin
						s_d.status = tuner_ctl_pkg::ST_BAD_PARM;
					end else if (tx_busy) begin
						s_d.status = tuner_ctl_pkg::ST_BUSY;
					end else begin
						s_d.status   = tuner_ctl_pkg::ST_GRANTED;
						s_d.tx_apply = 1'b1;
						s_d.tx_freq  = tx_f[15:0];
						s_d.tx_power = s_q.pay[2];
						unique case (s_q.pay[3][RATE_MSB_I:RATE_LSB_I])
							tuner_ctl_pkg::RATE_00: s_d.tx_rate = tuner_ctl_pkg::KBPS_256;
							tuner_ctl_pkg::RATE_10: s_d.tx_rate = tuner_ctl_pkg::KBPS_1544;
							default:                s_d.tx_rate = tuner_ctl_pkg::KBPS_3088;
						endcase
					end
				end else if (s_q.tag == tuner_ctl_pkg::TAG_RX_REQ) begin
					s_d.cnf_tag = tuner_ctl_pkg::TAG_RX_CNF;
					s_d.start   = 1'b1;
					if (!rx_present) begin
						s_d.status = tuner_ctl_pkg::ST_NO_PHYS;
					end else if (plen < tuner_ctl_pkg::RX_PAY_LEN
							|| s_q.pay[0][RX_HI_M:RX_HI_L] != '0) begin
						s_d.status = tuner_ctl_pkg::ST_BAD_PARM;
					end else if (rx_busy) begin
						s_d.status = tuner_ctl_pkg::ST_BUSY;
					end else begin
						// Tune now; the confirm waits for acquisition or the deadline.
						s_d.start    = 1'b0;
						s_d.st       = RX_WAIT;
						s_d.timer    = '0;
						s_d.rx_apply = 1'b1;
						s_d.rx_freq  = 18'(freq_x50({s_q.pay[0], s_q.pay[1]})) + tuner_ctl_pkg::RX_BASE_KHZ;
						s_d.rx_flip  = s_q.pay[2][tuner_ctl_pkg::FLIP_BIT];
						unique case (s_q.pay[2][RATE_MSB_I:RATE_LSB_I])
							tuner_ctl_pkg::RATE_00: s_d.rx_rate = tuner_ctl_pkg::KBPS_2048;
							tuner_ctl_pkg::RATE_01: s_d.rx_rate = tuner_ctl_pkg::KBPS_2048;
							tuner_ctl_pkg::RATE_10: s_d.rx_rate = tuner_ctl_pkg::KBPS_1544;
							default:                s_d.rx_rate = tuner_ctl_pkg::KBPS_3088;
						endcase
					end
				end else if (s_q.tag == tuner_ctl_pkg::TAG_IB_REQ) begin
					s_d.start   = 1'b1;
					s_d.cnf_tag = tuner_ctl_pkg::TAG_IB_CNF;
					s_d.lts_en  = multi_stream_mode;
					if (s_q.pay[0] == tuner_ctl_pkg::TYPE_ORIGIN && plen >= tuner_ctl_pkg::IB_ORG_LEN) begin
						if (ib_hw_fail) begin
							s_d.status = tuner_ctl_pkg::IB_HW_FAIL;
						end else if (ib_busy) begin
							s_d.status = tuner_ctl_pkg::IB_BUSY;
						end else begin
							s_d.status       = tuner_ctl_pkg::IB_ACCEPTED;
							s_d.ib_apply     = 1'b1;
							s_d.ib_by_origin = 1'b1;
							s_d.origin       = {s_q.pay[1], s_q.pay[2]};
							s_d.ib_no_origin = {s_q.pay[1], s_q.pay[2]} == 16'h0000;
						end
					end else if (s_q.pay[0] != tuner_ctl_pkg::TYPE_FREQ || plen < tuner_ctl_pkg::IB_FRQ_LEN
							|| (s_q.pay[3] != tuner_ctl_pkg::MOD_64QAM && s_q.pay[3] != tuner_ctl_pkg::MOD_256QAM)) begin
						s_d.status = tuner_ctl_pkg::IB_BAD_MOD;
					end else if (ib_f < IB_FREQ_MIN_KHZ || ib_f > IB_FREQ_MAX_KHZ) begin
						s_d.status = tuner_ctl_pkg::IB_BAD_FREQ;
					end else if (ib_hw_fail) begin
						s_d.status = tuner_ctl_pkg::IB_HW_FAIL;
					end else if (ib_busy) begin
						s_d.status = tuner_ctl_pkg::IB_BUSY;
					end else begin
						s_d.status       = tuner_ctl_pkg::IB_ACCEPTED;
						s_d.ib_apply     = 1'b1;
						s_d.ib_by_origin = 1'b0;
						s_d.ib_freq      = ib_f;
						s_d.ib_qam256    = s_q.pay[3] == tuner_ctl_pkg::MOD_256QAM;
					end
				end
			end
			RX_WAIT: begin
				// Confirm on acquisition, or at the deadline with other reasons.
				s_d.timer = s_q.timer + 26'h1;
				if (rx_acquired) begin
					s_d.start  = 1'b1;
					s_d.status = tuner_ctl_pkg::ST_GRANTED;
					s_d.st     = COLLECT;
				end else if (s_q.timer == 26'(RX_DEADLINE_CYCLES - 1)) begin
					s_d.start  = 1'b1;
					s_d.status = tuner_ctl_pkg::ST_OTHER;
					s_d.st     = COLLECT;
				end
			end
			default: begin
				s_d.st  = COLLECT;
				s_d.pos = 4'h0;
			end
		endcase
		// Input accepted only when collecting and no confirm is pending or leaving.
		s_d.in_ready = s_d.st == COLLECT && !s_d.start && !s_q.start && !ser_busy;
	end

	// State register.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// --------------------------------------------------------------------
	// Confirm sender.
	// --------------------------------------------------------------------
	confirm_sender u_sender (
		.clk       (clk),
		.rst       (rst),
		.start     (s_q.start),
		.tag       (s_q.cnf_tag),
		.status    (s_q.status),
		.lts_en    (s_q.lts_en),
		.lts       (s_q.lts),
		.out_ready (out_ready),
		.out_valid (out_valid),
		.out_byte  (out_byte),
		.out_last  (out_last),
		.busy      (ser_busy)
	);

	// Outputs straight from the state register.
	assign in_ready                  = s_q.in_ready;
	assign tx_apply                  = s_q.tx_apply;
	assign tx_freq_khz               = s_q.tx_freq;
	assign tx_power                  = s_q.tx_power;
	assign tx_rate_kbps              = s_q.tx_rate;
	assign rx_apply                  = s_q.rx_apply;
	assign receiver_carrier_setting  = s_q.rx_freq;
	assign rx_rate_kbps              = s_q.rx_rate;
	assign spectrum_flip_flag        = s_q.rx_flip;
	assign ib_apply                  = s_q.ib_apply;
	assign ib_by_origin              = s_q.ib_by_origin;
	assign programming_origin_number = s_q.origin;
	assign ib_no_origin              = s_q.ib_no_origin;
	assign ib_freq_khz               = s_q.ib_freq;
	assign ib_qam256                 = s_q.ib_qam256;

	// --------------------------------------------------------------------
	// Checks.
	// --------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_tx_no_path: assert property ((s_q.st == EVAL && s_q.tag == tuner_ctl_pkg::TAG_TX_REQ && !return_path_present)
		|=> (s_q.start && s_q.cnf_tag == tuner_ctl_pkg::TAG_TX_CNF && s_q.status == tuner_ctl_pkg::ST_NO_PHYS))
		else $error("missing not-available transmitter confirm");
	a_tx_grant_pair: assert property (s_q.tx_apply |-> s_q.start && s_q.status == tuner_ctl_pkg::ST_GRANTED
		&& s_q.cnf_tag == tuner_ctl_pkg::TAG_TX_CNF)
		else $error("transmitter applied without granted confirm");
	a_status_range: assert property (s_q.start |-> s_q.status < tuner_ctl_pkg::ST_RESERVED)
		else $error("reserved status sent");
	a_rx_early_cnf: assert property ((s_q.start && s_q.cnf_tag == tuner_ctl_pkg::TAG_RX_CNF
		&& s_q.status == tuner_ctl_pkg::ST_GRANTED) |-> $past(rx_acquired) && $past(s_q.st) == RX_WAIT)
		else $error("receiver confirm before acquisition");
	a_rx_deadline: assert property (s_q.st == RX_WAIT |-> s_q.timer < 26'(RX_DEADLINE_CYCLES))
		else $error("receiver wait passed its deadline");
	a_rx_freq_base: assert property (s_q.rx_apply |-> receiver_carrier_setting >= tuner_ctl_pkg::RX_BASE_KHZ
		&& s_q.st == RX_WAIT)
		else $error("receiver frequency below base");
	a_rx_rate_set: assert property (s_q.rx_apply |-> (s_q.rx_rate == tuner_ctl_pkg::KBPS_2048
		|| s_q.rx_rate == tuner_ctl_pkg::KBPS_1544 || s_q.rx_rate == tuner_ctl_pkg::KBPS_3088))
		else $error("receiver rate out of set");
	a_ib_lts_mode: assert property ((s_q.start && s_q.cnf_tag == tuner_ctl_pkg::TAG_IB_CNF)
		|-> s_q.lts_en == $past(multi_stream_mode))
		else $error("stream identifier mode mismatch");
	a_ib_no_origin: assert property ((s_q.ib_apply && s_q.ib_by_origin)
		|-> s_q.ib_no_origin == (s_q.origin == 16'h0000))
		else $error("origin zero flag wrong");
	a_ib_answered: assert property ((s_q.st == EVAL && s_q.tag == tuner_ctl_pkg::TAG_IB_REQ)
		|=> s_q.start && s_q.cnf_tag == tuner_ctl_pkg::TAG_IB_CNF ##1 ser_busy)
		else $error("inband request not answered");

	c_tx_grant: cover property (s_q.tx_apply);
	c_rx_timeout: cover property (s_q.start && s_q.cnf_tag == tuner_ctl_pkg::TAG_RX_CNF
		&& s_q.status == tuner_ctl_pkg::ST_OTHER);
	c_ib_multi: cover property (s_q.ib_apply && s_q.lts_en);

endmodule

//--- testbench/card_model.sv
// Card-side model that sends requests and collects confirm bytes.
module card_model (
	input  wire logic       clk,
	input  wire logic       in_ready,
	input  wire logic       out_valid,
	input  wire logic [7:0] out_byte,
	input  wire logic       out_last,
	output logic            in_valid,
	output logic [7:0]      in_byte,
	output logic            in_last,
	output logic            out_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       slow = 1'b0;
	logic [2:0] s;
	logic [7:0] ob;
	logic [7:0] rx_q[$];
	int         n_cnf = 0;
	initial begin
		{in_valid, in_byte, in_last, out_ready} = 11'h000;
	end
	// Samples the handshake just before the next rising edge.
	always @(negedge clk) begin
		s = {in_ready, out_valid & out_ready, out_last};
		ob = out_byte;
	end
	// Takes confirm bytes; stalls every other cycle when slow.
	always @(posedge clk) begin
		out_ready <= slow ? ~out_ready : 1'b1;
		if (s[1] === 1'b1) begin
			rx_q.push_back(ob);
			if (s[0]) n_cnf++;
		end
	end
	// Sends n bytes of m, top byte first, holding each until taken.
	task automatic send(input logic [63:0] m, input int n);
		for (int i = 0; i < n; i++) begin
			in_valid <= 1'b1;
			in_byte <= m[63-8*i-:8];
			in_last <= (i == n - 1);
			do @(posedge clk); while (s[2] !== 1'b1);
		end
		in_valid <= 1'b0;
		in_byte <= ~m[63-8*(n-1)-:8];
		in_last <= 1'b0;
	endtask
endmodule

//--- testbench/test_tuner_control_message_handler.sv
// Self-checking bench for the tuning message handler.
module test_tuner_control_message_handler;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RXD = 50;
	logic        clk = 1'b0, rst = 1'b1, path = 1'b1, tx_busy = 1'b0, rx_pres = 1'b1, rx_busy = 1'b0;
	logic        acq = 1'b0, ib_busy = 1'b0, hw_fail = 1'b0, multi = 1'b0;
	logic [7:0]  lts = 8'h5a;
	logic        in_valid, in_last, in_ready, out_valid, out_last, out_ready;
	logic        flip, by_org, no_org, q256, tx_ap, rx_ap, ib_ap;
	logic [7:0]  in_byte, out_byte, tx_pwr;
	logic [15:0] tx_freq, org;
	logic [11:0] tx_rate, rx_rate, txr[4], rxr[4];
	logic [17:0] rx_car;
	logic [21:0] ib_freq;
	int          miscompares = 0, n_tests = 0, k, n_tx = 0, n_rx = 0, n_ib = 0;
	initial forever #5 clk = ~clk;
	// Counts the one-cycle apply pulses at the falling edge, where they are settled.
	always @(negedge clk) begin
		if (tx_ap === 1'b1) n_tx <= n_tx + 1;
		if (rx_ap === 1'b1) n_rx <= n_rx + 1;
		if (ib_ap === 1'b1) n_ib <= n_ib + 1;
	end
	tuner_control_message_handler #(.RX_DEADLINE_CYCLES(RXD)) tuner_control_message_handler_inst (
		.clk(clk), .rst(rst), .in_valid(in_valid), .in_byte(in_byte), .in_last(in_last),
		.in_ready(in_ready), .out_valid(out_valid), .out_byte(out_byte), .out_last(out_last),
		.out_ready(out_ready), .return_path_present(path), .tx_busy(tx_busy), .rx_present(rx_pres),
		.rx_busy(rx_busy), .rx_acquired(acq), .ib_busy(ib_busy), .ib_hw_fail(hw_fail),
		.multi_stream_mode(multi), .local_stream_id(lts), .tx_apply(tx_ap), .tx_freq_khz(tx_freq),
		.tx_power(tx_pwr), .tx_rate_kbps(tx_rate), .rx_apply(rx_ap), .receiver_carrier_setting(rx_car),
		.rx_rate_kbps(rx_rate), .spectrum_flip_flag(flip), .ib_apply(ib_ap), .ib_by_origin(by_org),
		.programming_origin_number(org), .ib_no_origin(no_org), .ib_freq_khz(ib_freq), .ib_qam256(q256));
	card_model card_model_inst (.clk(clk), .in_ready(in_ready), .out_valid(out_valid), .out_byte(out_byte),
		.out_last(out_last), .in_valid(in_valid), .in_byte(in_byte), .in_last(in_last), .out_ready(out_ready));
	// Counts one comparison and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Sends one request and compares every byte of its confirm.
	task automatic run(input logic [23:0] tag, input logic [31:0] pay, input int n, input logic [7:0] ct,
		input logic [7:0] st, input int acq_at);
		logic [47:0] e;
		int          c, m;
		c = card_model_inst.n_cnf;
		card_model_inst.rx_q.delete();
		card_model_inst.send({tag, 8'(n), pay}, n + 4);
		for (k = 0; k < 4000 && card_model_inst.n_cnf == c; k++) begin
			if (k == acq_at) acq <= 1'b1;
			@(posedge clk);
		end
		acq <= 1'b0;
		m = (multi === 1'b1 && ct == 8'h09) ? 6 : 5;
		e = (m == 6) ? {16'h9f84, ct, 8'h02, lts, st} : {16'h009f, 8'h84, ct, 8'h01, st};
		chk(32'(card_model_inst.rx_q.size()), 32'(m));
		for (int i = 0; i < m && i < card_model_inst.rx_q.size(); i++)
			chk(card_model_inst.rx_q[i], e[8*(m-1-i)+:8]);
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Whole run is about 500 cycles; this allows 10000 cycles, about twenty times that.
	initial begin
		#100000;
		miscompares++;
		end_sim();
	end
	// -----------------------------------------------------------------
	// Test sequence.
	// -----------------------------------------------------------------
	initial begin
		txr = '{12'h100, 12'h100, 12'h608, 12'hc10};
		rxr = '{12'h800, 12'h800, 12'h608, 12'hc10};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		for (int r = 0; r < 4; r++) begin
			run(24'h9f8404, {16'h2710, 8'h10, 2'(r), 6'h00}, 4, 8'h05, r == 1 ? 8'h03 : 8'h00, -1);
			chk(tx_rate, txr[r]);
		end
		chk({tx_freq, tx_pwr}, 24'h271010);
		run(24'h9f8404, 32'h0010_1000, 4, 8'h05, 8'h03, -1);
		tx_busy <= 1'b1;
		run(24'h9f8404, 32'h2710_1000, 4, 8'h05, 8'h02, -1);
		path <= 1'b0;
		run(24'h9f8404, 32'h2710_1000, 4, 8'h05, 8'h01, -1);
		chk(n_tx, 32'h3);
		$display("transmitter test done");
		for (int r = 0; r < 4; r++) begin
			run(24'h9f8406, {16'h07ff, 2'(r), 5'h00, 1'(r), 8'h00}, 3, 8'h07, 8'h00, 10);
			chk(k > 10 && k < RXD, 1);
			chk(rx_car, 18'h2531e);
			chk({rx_rate, flip}, {rxr[r], 1'(r)});
		end
		run(24'h9f8406, 32'h0123_0000, 3, 8'h07, 8'h04, -1);
		chk(k >= RXD, 1);
		rx_busy <= 1'b1;
		run(24'h9f8406, 32'h0123_0000, 3, 8'h07, 8'h02, -1);
		rx_pres <= 1'b0;
		run(24'h9f8406, 32'h0123_0000, 3, 8'h07, 8'h01, -1);
		chk(n_rx, 32'h5);
		$display("receiver test done");
		card_model_inst.slow = 1'b1;
		run(24'h9f8408, 32'h0000_0000, 3, 8'h09, 8'h00, -1);
		chk({by_org, no_org}, 2'h3);
		run(24'h9f8408, 32'h0012_3400, 3, 8'h09, 8'h00, -1);
		chk({by_org, no_org, org}, 18'h21234);
		multi <= 1'b1;
		run(24'h9f8408, 32'h014e_2001, 4, 8'h09, 8'h00, -1);
		chk({by_org, ib_freq, q256}, 24'h1e8481);
		multi <= 1'b0;
		run(24'h9f8408, 32'h0103_e800, 4, 8'h09, 8'h00, -1);
		chk({ib_freq, q256}, 23'h0186a0);
		run(24'h9f8408, 32'h014e_2002, 4, 8'h09, 8'h02, -1);
		run(24'h9f8408, 32'h0103_e700, 4, 8'h09, 8'h01, -1);
		run(24'h9f8408, 32'h0200_0000, 3, 8'h09, 8'h02, -1);
		chk(ib_freq, 22'h00c350);
		hw_fail <= 1'b1;
		run(24'h9f8408, 32'h0103_e800, 4, 8'h09, 8'h03, -1);
		{hw_fail, ib_busy} <= 2'h1;
		run(24'h9f8408, 32'h0103_e800, 4, 8'h09, 8'h04, -1);
		chk(n_ib, 32'h4);
		$display("inband test done");
		end_sim();
	end
endmodule
